// *** logic/srp_refresh_ctl.sv ***
// Device-side refresh, self refresh and partial-array mask logic.
// Assumes pins come from the controller's domain and the sensor code is on mclk.
`default_nettype none
module srp_refresh_ctl #(
	parameter int NUM_BANKS = 8,
	parameter int NUM_SEGS  = 8,
	parameter int REFI_NS   = srp_pkg::REFI_NS_DEF,
	parameter int XSR_NS    = srp_pkg::XSR_NS_DEF,
	parameter int RFCPB_NS  = srp_pkg::RFCPB_NS_DEF
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	input  wire srp_pkg::srp_pins_t pins,
	input  wire logic [2:0]         temp_code,
	output logic                    self_ref,
	output logic                    int_clk_off,
	output logic                    exit_busy,
	output srp_pkg::srp_refresh_t   refresh,
	output logic [7:0]              bank_busy,
	output logic [7:0]              temperature_status_reg,
	output logic [7:0]              bank_mask_reg,
	output logic [7:0]              segment_mask_reg,
	output logic                    refresh_owed,
	output logic                    entry_error
);
	localparam int REFI_CYC  = (REFI_NS * 1000) / srp_pkg::MCLK_PS;
	localparam int XSR_CYC   = (XSR_NS * 1000 + srp_pkg::MCLK_PS - 1) / srp_pkg::MCLK_PS;
	localparam int RFCPB_CYC = (RFCPB_NS * 1000 + srp_pkg::MCLK_PS - 1) / srp_pkg::MCLK_PS;

	if (NUM_BANKS != 8 || NUM_SEGS != 8) begin : g_bad_geom
		$error("Only eight banks of eight segments are supported");
	end
	if (REFI_CYC < 1 || REFI_CYC > 65535 || XSR_CYC > 65535 || RFCPB_CYC > 255) begin : g_bad_t
		$error("Timing counts out of counter range");
	end

	typedef struct packed {
		srp_pkg::srp_mode_t    mode;
		logic                  ck_q;
		logic                  cke_prev;
		logic                  mrw_pend;
		logic [5:0]            ma_hi;
		logic [15:0]           timer;
		logic [15:0]           xsr_cnt;
		logic [7:0]            rfc_cnt;
		logic [2:0]            pb_bank;
		logic [3:0]            pb_count;
		logic                  owed;
		logic                  err;
		logic                  gated;
		logic [7:0]            busy;
		logic [7:0]            temp;
		logic [7:0]            bmask;
		logic [7:0]            smask;
		srp_pkg::srp_refresh_t ref_out;
	} state_t;

	state_t            s;
	state_t            next_s;
	srp_pkg::srp_pins_t p;

	srp_sync #(.W($bits(srp_pkg::srp_pins_t))) u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.d     (pins),
		.q     (p)
	);

	// Region index is bank * 8 + segment; set when both mask bits are clear
	function automatic logic [63:0] region_map(input logic [7:0] bm, input logic [7:0] sm);
		logic [63:0] r;
		r = '0;
		for (int b = 0; b < 8; b++) begin
			for (int g = 0; g < 8; g++) begin
				r[b*8+g] = !bm[b] && !sm[g];
			end
		end
		return r;
	endfunction

	function automatic logic is_ref(input srp_pkg::srp_pins_t x);
		return !x.cs_n && x.ca[2:0] == srp_pkg::REF_CODE;
	endfunction

	logic ck_rise;
	logic ck_fall;
	logic cmd_ok;
	logic ref_ab;
	logic ref_pb;
	logic sr_entry;
	logic mrw_cmd;
	logic [7:0] mrw_ma;
	logic [7:0] mrw_op;

	always_comb begin
		ck_rise  = p.ck && !s.ck_q;
		ck_fall  = !p.ck && s.ck_q;
		cmd_ok   = ck_rise && s.mode == srp_pkg::SRP_ACTIVE && s.cke_prev;
		ref_ab   = cmd_ok && p.cke && is_ref(p) && p.ca[srp_pkg::ALLBANK_BIT];
		ref_pb   = cmd_ok && p.cke && is_ref(p) && !p.ca[srp_pkg::ALLBANK_BIT];
		sr_entry = cmd_ok && !p.cke && is_ref(p);
		mrw_cmd  = cmd_ok && p.cke && !p.cs_n && p.ca[3:0] == srp_pkg::MRW_CODE;
		mrw_ma   = {s.ma_hi, p.ca[1:0]};
		mrw_op   = p.ca[9:2];
	end

	always_comb begin
		next_s               = s;
		next_s.ck_q          = p.ck;
		next_s.ref_out.pulse = 1'b0;
		next_s.temp          = {5'h00, temp_code};
		if (ck_rise) begin
			next_s.cke_prev = p.cke;
		end
		if (s.rfc_cnt != '0) begin
			next_s.rfc_cnt = s.rfc_cnt - 8'h01;
		end else begin
			next_s.busy = '0;
		end
		// Second half of a mode register write arrives on the falling edge
		if (ck_fall && s.mrw_pend) begin
			next_s.mrw_pend = 1'b0;
			if (mrw_ma == srp_pkg::BANK_MASK_MA) begin
				next_s.bmask = mrw_op;
			end
			if (mrw_ma == srp_pkg::SEG_MASK_MA) begin
				next_s.smask = mrw_op;
			end
		end
		unique case (s.mode)
			srp_pkg::SRP_ACTIVE: begin
				if (mrw_cmd) begin
					next_s.mrw_pend = 1'b1;
					next_s.ma_hi    = p.ca[9:4];
				end
				if (ref_ab) begin
					next_s.pb_bank  = '0;
					next_s.pb_count = '0;
					next_s.owed     = 1'b0;
					next_s.ref_out  = '{pulse: 1'b1, all: 1'b1, bank: '0, region: '1};
				end
				if (ref_pb) begin
					next_s.pb_bank = (s.pb_bank == srp_pkg::PB_LAST) ? '0 : s.pb_bank + 3'h1;
					next_s.busy    = 8'h01 << s.pb_bank;
					next_s.rfc_cnt = 8'(RFCPB_CYC);
					next_s.ref_out = '{pulse: 1'b1, all: 1'b0, bank: s.pb_bank,
						region: 64'hff << {s.pb_bank, 3'h0}};
					if (s.pb_count + 4'h1 >= srp_pkg::PB_PER_AB) begin
						next_s.owed     = 1'b0;
						next_s.pb_count = '0;
					end else begin
						next_s.pb_count = s.pb_count + 4'h1;
					end
				end
				if (sr_entry) begin
					next_s.mode     = srp_pkg::SRP_SELFREF;
					next_s.gated    = 1'b1;
					next_s.timer    = '0;
					next_s.mrw_pend = 1'b0;
					next_s.err      = s.owed;
				end
			end
			srp_pkg::SRP_SELFREF: begin
				// Only clock enable is looked at here
				if (s.timer == '0) begin
					next_s.timer   = 16'(REFI_CYC);
					next_s.ref_out = '{pulse: 1'b1, all: 1'b1, bank: '0,
						region: region_map(s.bmask, s.smask)};
				end else begin
					next_s.timer = s.timer - 16'h0001;
				end
				if (ck_rise && p.cke) begin
					next_s.mode    = srp_pkg::SRP_EXITING;
					next_s.gated   = 1'b0;
					next_s.xsr_cnt = 16'(XSR_CYC);
				end
			end
			srp_pkg::SRP_EXITING: begin
				if (ck_rise && !p.cke) begin
					next_s.mode  = srp_pkg::SRP_SELFREF;
					next_s.gated = 1'b1;
					next_s.timer = '0;
				end else if (s.xsr_cnt <= 16'h0001) begin
					next_s.mode     = srp_pkg::SRP_ACTIVE;
					next_s.owed     = 1'b1;
					next_s.pb_count = '0;
					next_s.cke_prev = 1'b1;
				end else begin
					next_s.xsr_cnt = s.xsr_cnt - 16'h0001;
				end
			end
			default: begin
				next_s.mode = srp_pkg::SRP_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign self_ref               = s.mode == srp_pkg::SRP_SELFREF;
	assign int_clk_off            = s.gated;
	assign exit_busy              = s.mode == srp_pkg::SRP_EXITING;
	assign refresh                = s.ref_out;
	assign bank_busy              = s.busy;
	assign temperature_status_reg = s.temp;
	assign bank_mask_reg          = s.bmask;
	assign segment_mask_reg       = s.smask;
	assign refresh_owed           = s.owed;
	assign entry_error            = s.err;

	default clocking cb @(posedge mclk iff ce);
	endclocking
	default disable iff (!rst_n);

	sequence seq_entry;
		sr_entry;
	endsequence
	sequence seq_gated_run;
		s.gated && s.mode == srp_pkg::SRP_SELFREF;
	endsequence

	chk_entry_decode: assert property (seq_entry |=> seq_gated_run)
		else $error("Self refresh entry not taken");
	chk_clock_gated: assert property (s.mode == srp_pkg::SRP_SELFREF |-> s.gated)
		else $error("Internal clock running in self refresh");
	chk_first_refresh: assert property (seq_entry |=> ##1 (s.ref_out.pulse && s.ref_out.all))
		else $error("No internal refresh after entry");
	chk_pb_advance: assert property (ref_pb |=> s.pb_bank == 3'($past(s.pb_bank) + 3'h1))
		else $error("Per-bank counter did not advance");
	chk_ab_reset: assert property (ref_ab |=> s.pb_bank == '0 && !s.owed)
		else $error("All-bank refresh did not clear counter");
	chk_region_mask: assert property (self_ref && s.ref_out.pulse |->
		s.ref_out.region == region_map(s.bmask, s.smask))
		else $error("Refreshed region ignores masks");
	chk_mask_write: assert property (ck_fall && s.mrw_pend && mrw_ma == srp_pkg::BANK_MASK_MA
		|=> s.bmask == $past(mrw_op))
		else $error("Bank mask write lost");
	chk_sr_ignores: assert property (s.mode == srp_pkg::SRP_SELFREF |=>
		$stable(s.pb_bank) && $stable(s.bmask) && $stable(s.smask))
		else $error("State changed by inputs in self refresh");
	chk_pb_credit: assert property (ref_pb && s.pb_count == 4'h7 |=> !s.owed)
		else $error("Eight per-bank refreshes did not count");
	chk_bank_busy: assert property (ref_pb |=> s.busy == (8'h01 << $past(s.pb_bank)))
		else $error("Wrong bank marked busy");
	chk_masked_bank: assert property (self_ref && s.ref_out.pulse && s.bmask[0] |->
		s.ref_out.region[7:0] == '0)
		else $error("Masked bank refreshed");
endmodule
`default_nettype wire

// *** logic/srp_pkg.sv ***
// Constants, types and pin bundle for the refresh and self refresh block.
// Assumes the command pins arrive unsynchronised and the core clock is 200 MHz.
`default_nettype none
package srp_pkg;
	localparam int          CA_W           = 10;
	localparam int          MCLK_PS        = 5000;
	localparam logic [7:0]  TEMP_STATUS_MA = 8'h04;
	localparam logic [7:0]  BANK_MASK_MA   = 8'h10;
	localparam logic [7:0]  SEG_MASK_MA    = 8'h11;
	localparam logic [2:0]  REF_CODE       = 3'h4;
	localparam int          ALLBANK_BIT    = 3;
	localparam logic [3:0]  MRW_CODE       = 4'h0;
	localparam logic [2:0]  PB_LAST        = 3'h7;
	localparam logic [3:0]  PB_PER_AB      = 4'h8;
	localparam int          REFI_NS_DEF    = 3900;
	localparam int          XSR_NS_DEF     = 140;
	localparam int          RFCPB_NS_DEF   = 60;

	typedef enum logic [1:0] {
		SRP_ACTIVE,
		SRP_SELFREF,
		SRP_EXITING
	} srp_mode_t;

	typedef struct packed {
		logic            ck;
		logic            cke;
		logic            cs_n;
		logic [CA_W-1:0] ca;
	} srp_pins_t;

	typedef struct packed {
		logic        pulse;
		logic        all;
		logic [2:0]  bank;
		logic [63:0] region;
	} srp_refresh_t;
endpackage
`default_nettype wire

// *** logic/srp_sync.sv ***
// Two-flop synchroniser for a bundle of level inputs.
// Assumes each bit may change at any time relative to mclk.
`default_nettype none
module srp_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// *** verif/srp_ctl_model.sv ***
// Controller model: drives ck, cke, chip select and the command bits.
// Assumes one caller at a time; ck stands still between task calls.
`default_nettype none
module srp_ctl_model (
	output var srp_pkg::srp_pins_t pins
);
	timeunit 1ns;
	timeprecision 100ps;
	initial pins = '{ck: 1'b0, cke: 1'b1, cs_n: 1'b1, ca: 10'h3ff};
	// One ck period: r is sampled at the rise, f at the fall
	task automatic cyc(input logic k, input logic s_n, input logic [9:0] r, input logic [9:0] f);
		pins.cke = k;
		pins.cs_n = s_n;
		pins.ca = r;
		#20 pins.ck = 1'b1;
		#20 pins.ca = f;
		#20 pins.ck = 1'b0;
		#20;
	endtask
	// Deselected: command bits are inverted for the rise and go back to their old value for the fall
	task automatic nop(input logic k);
		cyc(k, 1'b1, ~pins.ca, pins.ca);
	endtask
	task automatic mode_reg_write_cmd(input logic [7:0] ma, input logic [7:0] op);
		cyc(1'b1, 1'b0, {ma[7:2], 4'h0}, {op, ma[1:0]});
	endtask
endmodule
`default_nettype wire

// *** verif/sdram_refresh_selfrefresh_partial_array_selfrefresh_test.sv ***
// Testbench: controller model on the pins, queue model of refresh results.
// Assumes the block is built with a short refresh interval for simulation.
`default_nettype none
module sdram_refresh_selfrefresh_partial_array_selfrefresh_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic                  mclk, rst_n, ce;
	logic [2:0]            temp_code;
	srp_pkg::srp_pins_t    pins;
	srp_pkg::srp_refresh_t refresh;
	logic                  self_ref, int_clk_off, exit_busy, refresh_owed, entry_error;
	logic [7:0]            bank_busy, temp_reg, bm_reg, sm_reg, bm, sm;
	logic [31:0]           rng = 32'h36;
	int                    n_mismatch = 0, num_checks = 0, cycles = 0, sr_pulses = 0;
	int                    pb = 0, pbn = 8, owed = 0;
	int                    exp_q[$];
	srp_ctl_model ctl (.pins(pins));
	srp_refresh_ctl #(.REFI_NS(100)) uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .pins(pins),
		.temp_code(temp_code), .self_ref(self_ref), .int_clk_off(int_clk_off),
		.exit_busy(exit_busy), .refresh(refresh), .bank_busy(bank_busy),
		.temperature_status_reg(temp_reg), .bank_mask_reg(bm_reg),
		.segment_mask_reg(sm_reg), .refresh_owed(refresh_owed), .entry_error(entry_error));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [63:0] sr_region();
		logic [63:0] r;
		for (int i = 0; i < 64; i++) r[i] = !bm[i/8] && !sm[i%8];
		return r;
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic ref_cmd(input logic all);
		logic [7:0] exp_busy;
		exp_busy = 8'h00;
		if (all) begin
			exp_q.push_back(-1);
			pb = 0;
		end else begin
			exp_q.push_back(pb);
			exp_busy = 8'h01 << pb;
			pb = (pb + 1) % 8;
		end
		pbn = all ? 8 : pbn + 1;
		if (pbn >= 8) owed = 0;
		ctl.cyc(1'b1, 1'b0, {6'h00, all, srp_pkg::REF_CODE}, 10'h155);
		@(negedge mclk);
		chk(bank_busy, exp_busy);
		repeat (8) @(posedge mclk);
		chk(refresh_owed, owed[0]);
		chk(bank_busy, 8'h00);
	endtask
	task automatic sref(input logic err, input logic again);
		sr_pulses = 0;
		ctl.nop(1'b1);
		ctl.cyc(1'b0, 1'b0, {7'h00, srp_pkg::REF_CODE}, 10'h2aa);
		ctl.nop(1'b0);
		repeat (80) @(posedge mclk);
		// Start an exit, then drop clock enable again inside the exit delay
		if (again) begin
			ctl.nop(1'b1);
			@(negedge mclk);
			chk({self_ref, int_clk_off, exit_busy}, 3'b001);
			ctl.nop(1'b0);
			@(negedge mclk);
			chk({self_ref, int_clk_off, exit_busy}, 3'b110);
			repeat (80) @(posedge mclk);
		end
		repeat (2) ctl.cyc(1'b0, 1'b0, {7'h01, srp_pkg::REF_CODE}, 10'h155);
		@(negedge mclk);
		chk(self_ref & int_clk_off, 1'b1);
		chk(sr_pulses > 1, 1'b1);
		chk(entry_error, err);
		repeat (4) ctl.nop(1'b1);
		@(negedge mclk);
		chk({self_ref, exit_busy, refresh_owed}, 3'b001);
		owed = 1;
		pbn = 0;
		$display("self refresh pass done");
	endtask
	always @(posedge mclk) begin
		int e;
		cycles++;
		if (cycles > 20000) begin
			n_mismatch++;
			end_of_test();
		end
		if (refresh.pulse === 1'b1) begin
			if (self_ref || exit_busy) begin
				sr_pulses++;
				chk(refresh.all, 1'b1);
				chk(refresh.region, sr_region());
			end else if (exp_q.size() == 0) chk(refresh.pulse, 1'b0);
			else begin
				e = exp_q.pop_front();
				chk(refresh.all, e < 0);
				if (e >= 0) chk(refresh.bank, e[2:0]);
				if (e >= 0) chk(refresh.region, 64'hff << (e * 8));
			end
		end
	end
	initial begin
		rst_n = 1'b0;
		ce = 1'b0;
		temp_code = 3'h0;
		repeat (16) @(posedge mclk);
		chk({bm_reg, sm_reg, self_ref, refresh.pulse}, 18'h0);
		rst_n <= 1'b1;
		ce <= 1'b1;
		repeat (2) ctl.nop(1'b1);
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk) temp_code <= i[2:0];
			@(posedge mclk);
			@(negedge mclk);
			chk(temp_reg, {5'h00, i[2:0]});
		end
		// Clock enable low must freeze the status copy
		@(posedge mclk) begin
			ce <= 1'b0;
			temp_code <= 3'h2;
		end
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		chk(temp_reg, 8'h07);
		@(posedge mclk) ce <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		chk(temp_reg, 8'h02);
		$display("temperature code test done");
		bm = 8'(xs());
		sm = 8'(xs());
		ctl.mode_reg_write_cmd(srp_pkg::BANK_MASK_MA, bm);
		ctl.mode_reg_write_cmd(srp_pkg::SEG_MASK_MA, sm);
		ctl.mode_reg_write_cmd(srp_pkg::TEMP_STATUS_MA, ~bm);
		@(negedge mclk);
		chk({bm_reg, sm_reg}, {bm, sm});
		$display("mask register test done");
		repeat (9) ref_cmd(1'b0);
		ref_cmd(1'b1);
		ref_cmd(1'b0);
		$display("refresh counter test done");
		sref(1'b0, 1'b0);
		sref(1'b1, 1'b1);
		repeat (8) ref_cmd(1'b0);
		sref(1'b0, 1'b0);
		ref_cmd(1'b1);
		chk(exp_q.size(), 0);
		$display("post exit refresh test done");
		end_of_test();
	end
endmodule
`default_nettype wire
